/* File: rtl/sbcc_params.svh */
`ifndef SBCC_PARAMS_SVH
`define SBCC_PARAMS_SVH
`define SBCC_MODE_BUS 7
`define SBCC_MODE_CPU 6
`define SBCC_MODE_RSV_HI 5
`define SBCC_MODE_RSV_LO 3
`define SBCC_CFG_REL 7
`define SBCC_CFG_WT_HI 6
`define SBCC_CFG_WT_LO 4
`define SBCC_CFG_LOW_RST 4'hC
`define SBCC_PAGE_RST 8'h00
`define SBCC_CS0_ROM_HI 4'h3
`define SBCC_CS1_HI 4'h1
`define SBCC_CS2_HI 4'h2
`define SBCC_LOW_HI 4'h0
`define SBCC_IRAM_LO 24'h00D800
`define SBCC_IRAM_HI 24'h00F7FF
`define SBCC_INT_LO 24'h00D800
`define SBCC_INT_HI 24'h00FFFF
`endif

/* File: rtl/sbcc_pkg.sv */
package sbcc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_T1 = 3'b001,
        ST_T2 = 3'b010,
        ST_T3 = 3'b011,
        ST_WAIT = 3'b100,
        ST_T4 = 3'b101,
        ST_REL = 3'b110
    } sbcc_bus_st_t;

    typedef struct packed {
        logic [3:0] cnt;
    } sbcc_wait_t;

    typedef struct packed {
        logic [21:0] r;
        logic [7:0] p_out;
        logic [7:0] p_oe;
        logic [3:0] r3;
    } sbcc_pins_t;

    typedef struct packed {
        logic strap_done;
        logic rom_off;
        logic bus_mode_select;
        logic cpu_size_mode_select;
        logic [2:0] mode_rsv;
        logic [2:0] cs_en;
        logic [7:0] stack_page_register;
        logic bus_release_enable;
        logic [2:0] wait_state_field;
        logic [3:0] cfg_low;
        logic mode_wr;
        logic page_wr;
        logic mask_hold;
        logic int_mask;
        sbcc_bus_st_t st;
        logic [23:0] addr;
        logic wr;
        logic [7:0] wdata;
        logic ext;
        logic [2:0] cs_sel;
        logic [2:0] acc_wait;
        logic slow;
        logic done;
        logic [7:0] rdata;
        logic grant;
        logic [23:0] stack_addr;
        logic in_bit3;
        sbcc_pins_t pins;
    } sbcc_state_t;
endpackage : sbcc_pkg

/* File: rtl/sbcc_wait_gen.sv */
`timescale 1ns/1ns
// Counts 2*code clock-cycle wait states
module sbcc_wait_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    input wire logic [2:0] code,
    // Status
    output logic busy,
    output logic last
);
    sbcc_pkg::sbcc_wait_t s, n;

    always_comb begin
        n = s;
        if (start) begin
            n.cnt = {code, 1'b0};
        end else if (s.cnt != 4'h0) begin
            n.cnt = s.cnt - 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign busy = (s.cnt != 4'h0);
    assign last = (s.cnt == 4'h1);
endmodule : sbcc_wait_gen

/* File: rtl/sbcc_top.sv */
`timescale 1ns/1ns
`include "sbcc_params.svh"
module sbcc_top (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Strap and clock source
    input wire logic PROCESSOR_TYPE_PIN,
    input wire logic LOW_SPEED_OSCILLATOR,
    // Software writes
    input wire logic WR_MODE,
    input wire logic WR_STACK_PAGE,
    input wire logic WR_CONFIG,
    input wire logic [7:0] WR_DATA,
    input wire logic INSTR_END,
    // Register readback
    output logic [7:0] MODE_REG,
    output logic [7:0] STACK_PAGE_REG,
    output logic [7:0] CONFIG_REG,
    // Status
    output logic BUS_EXPANSION,
    output logic CPU_MAXIMUM,
    output logic INTERNAL_ROM_EN,
    output logic INT_MASK,
    // CPU access
    input wire logic ACC_REQ,
    input wire logic ACC_WRITE,
    input wire logic [23:0] ACC_ADDR,
    input wire logic [7:0] ACC_WDATA,
    output logic ACC_DONE,
    output logic [7:0] ACC_RDATA,
    output logic ACC_EXTERNAL,
    // Stack
    input wire logic [15:0] STACK_POINTER,
    output logic [23:0] STACK_ADDR,
    // Port function data
    input wire logic [21:0] PORT_R_DATA,
    input wire logic [7:0] PORT_P_DATA,
    input wire logic [7:0] PORT_P_OE,
    input wire logic [3:0] PORT_BITS_30_33,
    // Pins
    output logic [21:0] PIN_R_OUT,
    input wire logic [7:0] PIN_P_IN,
    output logic [7:0] PIN_P_OUT,
    output logic [7:0] PIN_P_OE,
    output logic [3:0] PIN_BITS_30_33,
    input wire logic BUS_REQUEST_IN,
    output logic INPUT_PORT_BIT_3,
    output logic BUS_GRANT
);
    localparam sbcc_pkg::sbcc_state_t RST_VAL = '{
        int_mask: 1'b1,
        cfg_low: `SBCC_CFG_LOW_RST,
        stack_page_register: `SBCC_PAGE_RST,
        st: sbcc_pkg::ST_IDLE,
        default: '0
    };

    logic [1:0] rst_sync_ff;
    logic rst_n;
    sbcc_pkg::sbcc_state_t s, n;
    logic start_wait;
    logic wait_busy;
    logic wait_last;
    logic [3:0] dec;
    logic bus_on;
    logic rd_ph;
    logic wr_ph;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // {external, select 2, select 1, select 0}
    function automatic logic [3:0] decode_region(input logic [23:0] a, input logic rom_off,
                                                 input logic bus_exp);
        logic internal;
        logic [3:0] hi;
        logic [3:0] r;
        hi = a[23:20];
        if (rom_off) begin
            internal = (a >= `SBCC_INT_LO) && (a <= `SBCC_INT_HI);
        end else begin
            internal = (hi == `SBCC_LOW_HI);
        end
        r[3] = bus_exp && !internal;
        r[0] = r[3] && (rom_off ? (hi == `SBCC_LOW_HI) : (hi == `SBCC_CS0_ROM_HI));
        r[1] = r[3] && (hi == `SBCC_CS1_HI);
        r[2] = r[3] && (hi == `SBCC_CS2_HI);
        return r;
    endfunction : decode_region

    assign dec = decode_region(ACC_ADDR, s.rom_off, s.bus_mode_select);
    // Internal and low-speed accesses skip the wait phase entirely
    assign start_wait = (s.st == sbcc_pkg::ST_T3) && s.ext && !s.slow && (s.acc_wait != 3'h0);

    sbcc_wait_gen u_wait (
        .clk(CLK),
        .rst_n(rst_n),
        .start(start_wait),
        .code(s.acc_wait),
        .busy(wait_busy),
        .last(wait_last)
    );

    always_comb begin
        n = s;
        n.done = 1'b0;
        n.in_bit3 = BUS_REQUEST_IN;
        if (!s.strap_done) begin
            // Strap taken once, after reset release
            n.strap_done = 1'b1;
            n.rom_off = !PROCESSOR_TYPE_PIN;
            n.bus_mode_select = !PROCESSOR_TYPE_PIN;
            n.cpu_size_mode_select = 1'b0;
            n.cs_en = {2'h0, !PROCESSOR_TYPE_PIN};
        end else begin
            if (WR_MODE) begin
                // Without internal ROM single chip is meaningless, so bus bit is held
                n.bus_mode_select = s.rom_off | WR_DATA[`SBCC_MODE_BUS];
                n.cpu_size_mode_select = WR_DATA[`SBCC_MODE_CPU];
                n.mode_rsv = WR_DATA[`SBCC_MODE_RSV_HI:`SBCC_MODE_RSV_LO];
                n.cs_en = WR_DATA[2:0];
            end
            if (WR_STACK_PAGE) begin
                n.stack_page_register = WR_DATA;
            end
            if (WR_CONFIG) begin
                n.bus_release_enable = WR_DATA[`SBCC_CFG_REL];
                n.wait_state_field = WR_DATA[`SBCC_CFG_WT_HI:`SBCC_CFG_WT_LO];
                n.cfg_low = WR_DATA[3:0];
            end
        end
        n.mode_wr = s.mode_wr | WR_MODE;
        n.page_wr = s.page_wr | WR_STACK_PAGE;
        if (WR_STACK_PAGE) begin
            n.mask_hold = 1'b1;
        end else if (INSTR_END) begin
            n.mask_hold = 1'b0;
        end
        n.int_mask = !(n.mode_wr && n.page_wr) || n.mask_hold;
        case (s.st)
            sbcc_pkg::ST_IDLE: begin
                // New enable value so a clearing write never leaves a grant behind
                if (n.bus_release_enable && !BUS_REQUEST_IN) begin
                    n.st = sbcc_pkg::ST_REL;
                    n.grant = 1'b1;
                    n.ext = 1'b0;
                    n.cs_sel = 3'h0;
                end else if (ACC_REQ && !s.done) begin
                    n.st = sbcc_pkg::ST_T1;
                    n.addr = ACC_ADDR;
                    n.wr = ACC_WRITE;
                    n.wdata = ACC_WDATA;
                    n.ext = dec[3];
                    n.cs_sel = dec[2:0];
                    n.acc_wait = s.wait_state_field;
                    n.slow = LOW_SPEED_OSCILLATOR;
                end
            end
            sbcc_pkg::ST_T1: begin
                n.st = sbcc_pkg::ST_T2;
            end
            sbcc_pkg::ST_T2: begin
                n.st = sbcc_pkg::ST_T3;
            end
            sbcc_pkg::ST_T3: begin
                n.st = start_wait ? sbcc_pkg::ST_WAIT : sbcc_pkg::ST_T4;
            end
            sbcc_pkg::ST_WAIT: begin
                if (wait_last || !wait_busy) begin
                    n.st = sbcc_pkg::ST_T4;
                end
            end
            sbcc_pkg::ST_T4: begin
                n.st = sbcc_pkg::ST_IDLE;
                n.done = 1'b1;
                if (s.ext && !s.wr) begin
                    n.rdata = PIN_P_IN;
                end
                n.ext = 1'b0;
                n.cs_sel = 3'h0;
            end
            sbcc_pkg::ST_REL: begin
                if (BUS_REQUEST_IN || !n.bus_release_enable) begin
                    n.st = sbcc_pkg::ST_IDLE;
                    n.grant = 1'b0;
                end
            end
            default: begin
                n.st = sbcc_pkg::ST_IDLE;
            end
        endcase
        n.stack_addr = {n.stack_page_register, STACK_POINTER};
        bus_on = (n.st != sbcc_pkg::ST_IDLE) && (n.st != sbcc_pkg::ST_REL);
        rd_ph = bus_on && (n.st != sbcc_pkg::ST_T1);
        wr_ph = (n.st == sbcc_pkg::ST_T3) || (n.st == sbcc_pkg::ST_WAIT);
        if (n.bus_mode_select) begin
            n.pins.r = {!(n.ext && n.wr && wr_ph), !(n.ext && !n.wr && rd_ph), n.addr[19:0]};
            n.pins.p_out = n.wdata;
            n.pins.p_oe = {8{n.ext && n.wr && rd_ph}};
        end else begin
            n.pins.r = PORT_R_DATA;
            n.pins.p_out = PORT_P_DATA;
            n.pins.p_oe = PORT_P_OE;
        end
        for (int i = 0; i < 3; i++) begin
            if (n.bus_mode_select && n.cs_en[i]) begin
                n.pins.r3[i] = !(bus_on && n.ext && n.cs_sel[i]);
            end else begin
                n.pins.r3[i] = PORT_BITS_30_33[i];
            end
        end
        n.pins.r3[3] = n.bus_release_enable ? !n.grant : PORT_BITS_30_33[3];
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            s <= RST_VAL;
        end else begin
            s <= n;
        end
    end

    assign MODE_REG = {s.bus_mode_select, s.cpu_size_mode_select, s.mode_rsv, s.cs_en};
    assign STACK_PAGE_REG = s.stack_page_register;
    assign CONFIG_REG = {s.bus_release_enable, s.wait_state_field, s.cfg_low};
    assign BUS_EXPANSION = s.bus_mode_select;
    assign CPU_MAXIMUM = s.cpu_size_mode_select;
    assign INTERNAL_ROM_EN = !s.rom_off;
    assign INT_MASK = s.int_mask;
    assign ACC_DONE = s.done;
    assign ACC_RDATA = s.rdata;
    assign ACC_EXTERNAL = s.ext;
    assign STACK_ADDR = s.stack_addr;
    assign PIN_R_OUT = s.pins.r;
    assign PIN_P_OUT = s.pins.p_out;
    assign PIN_P_OE = s.pins.p_oe;
    assign PIN_BITS_30_33 = s.pins.r3;
    assign INPUT_PORT_BIT_3 = s.in_bit3;
    assign BUS_GRANT = s.grant;

    // Checking helper: wait cycles seen in the current access
    logic [4:0] wcnt_ff;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            wcnt_ff <= 5'h00;
        end else if (s.st == sbcc_pkg::ST_WAIT) begin
            wcnt_ff <= wcnt_ff + 5'h01;
        end else if (s.st == sbcc_pkg::ST_T1) begin
            wcnt_ff <= 5'h00;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    a_mode_write: assert property (s.strap_done && WR_MODE && !s.rom_off |=>
        BUS_EXPANSION == $past(WR_DATA[7]) && CPU_MAXIMUM == $past(WR_DATA[6]))
        else $error("mode bits not taken from write");
    a_strap_rom: assert property ($rose(s.strap_done) && $past(PROCESSOR_TYPE_PIN) |->
        !BUS_EXPANSION && !CPU_MAXIMUM && INTERNAL_ROM_EN)
        else $error("rom strap did not give single chip minimum");
    a_strap_norom: assert property ($rose(s.strap_done) && !$past(PROCESSOR_TYPE_PIN) |->
        BUS_EXPANSION && !CPU_MAXIMUM && !INTERNAL_ROM_EN && MODE_REG[2:0] == 3'h1)
        else $error("no-rom strap did not give expansion with select 0");
    a_pins_port: assert property (s.strap_done && $past(s.strap_done) && !BUS_EXPANSION |->
        PIN_R_OUT == $past(PORT_R_DATA) && PIN_P_OE == $past(PORT_P_OE))
        else $error("single chip pins not following port data");
    a_sel_region: assert property (BUS_EXPANSION && MODE_REG[1] && !PIN_BITS_30_33[1] |->
        s.ext && s.st != sbcc_pkg::ST_IDLE && s.addr[23:20] == 4'h1)
        else $error("select 1 outside its region");
    a_bus_held: assert property (s.strap_done && s.rom_off |-> BUS_EXPANSION)
        else $error("single chip reached without internal rom");
    a_sel_disabled: assert property (s.strap_done && $past(s.strap_done) && !MODE_REG[0] |->
        PIN_BITS_30_33[0] == $past(PORT_BITS_30_33[0]))
        else $error("disabled select 0 not acting as port");
    a_sel_internal: assert property (s.st == sbcc_pkg::ST_T2 && !s.ext && BUS_EXPANSION |->
        (PIN_BITS_30_33[2:0] | ~MODE_REG[2:0]) == 3'h7)
        else $error("select asserted on internal access");
    a_wait_len: assert property (s.st == sbcc_pkg::ST_T4 && $past(s.st) == sbcc_pkg::ST_WAIT |->
        wcnt_ff == {1'b0, s.acc_wait, 1'b0})
        else $error("wait length wrong");
    a_no_wait: assert property (s.st == sbcc_pkg::ST_T3 && (!s.ext || s.slow) |=>
        s.st == sbcc_pkg::ST_T4)
        else $error("wait inserted on internal or slow access");
    a_page_reset: assert property ($rose(s.strap_done) |-> STACK_PAGE_REG == 8'h00)
        else $error("stack page not zero after reset");
    // First edge after reset still shows the reset address, not the pointer
    a_stack_wrap: assert property ($past(rst_n) |-> STACK_ADDR == {STACK_PAGE_REG, $past(STACK_POINTER)})
        else $error("stack address not page plus pointer");
    a_int_init: assert property (!s.mode_wr || !s.page_wr |-> INT_MASK)
        else $error("interrupts open before setup");
    a_int_hold: assert property (WR_STACK_PAGE |=> INT_MASK ##1 INT_MASK)
        else $error("interrupts open right after stack page write");
    a_release_gate: assert property (!CONFIG_REG[7] |-> !BUS_GRANT)
        else $error("grant without release enable");
    a_ram_internal: assert property (s.st == sbcc_pkg::ST_T1 &&
        s.addr >= `SBCC_IRAM_LO && s.addr <= `SBCC_IRAM_HI |-> !s.ext)
        else $error("internal ram treated as external");

    c_wait_access: cover property (s.st == sbcc_pkg::ST_WAIT ##1 s.st == sbcc_pkg::ST_T4);
    c_release: cover property (BUS_GRANT ##1 !BUS_GRANT);
    c_sel0_ext: cover property (!PIN_BITS_30_33[0] && MODE_REG[0]);
    c_unmasked: cover property ($fell(INT_MASK));
endmodule : sbcc_top

/* File: tb/sbcc_ext_mem.sv */
`timescale 1ns/1ns
// External byte memory on the expansion bus
module sbcc_ext_mem (
    // Bus pins
    input wire logic [21:0] pin_r,
    input wire logic [7:0] pin_p_out,
    input wire logic [7:0] pin_p_oe,
    output logic [7:0] pin_p_in
);
    logic [7:0] mem [0:255];
    logic [7:0] last_v;
    initial begin
        last_v = 8'h00;
        for (int i = 0; i < 256; i++) begin
            mem[i] = i[7:0] ^ 8'h5A;
        end
    end
    // Byte taken while the write strobe is low and data is driven
    always @(pin_r or pin_p_out or pin_p_oe) begin
        if (!pin_r[21] && pin_r[20] && pin_p_oe == 8'hFF) begin
            mem[pin_r[7:0]] = pin_p_out;
        end
    end
    always @(negedge pin_r[20]) begin
        last_v = mem[pin_r[7:0]];
    end
    // Released bus shows the inverse so a stale value never matches
    always @* begin
        if (!pin_r[20]) begin
            pin_p_in = mem[pin_r[7:0]];
        end else begin
            pin_p_in = ~last_v;
        end
    end
endmodule : sbcc_ext_mem

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    logic CLK = 1'b0, RESETN = 1'b0, PT = 1'b1, LOW = 1'b0, WM = 1'b0, WP = 1'b0, WC = 1'b0, IE = 1'b0;
    logic [7:0] WD = 8'h00, MODE_REG, STACK_PAGE_REG, CONFIG_REG, ACC_RDATA, PORT_P_DATA = 8'h00;
    logic BUS_EXPANSION, CPU_MAXIMUM, INTERNAL_ROM_EN, INT_MASK, ACC_DONE, ACC_EXTERNAL, IN3, BUS_GRANT;
    logic REQ = 1'b0, AWR = 1'b0, BRQ = 1'b1;
    logic [23:0] AADR = 24'h000000, STACK_ADDR;
    logic [7:0] AWD = 8'h00, PORT_P_OE = 8'h00, PIN_P_IN, PIN_P_OUT, PIN_P_OE;
    logic [15:0] SPV = 16'h0000;
    logic [21:0] PORT_R_DATA = 22'h000000, PIN_R_OUT;
    logic [3:0] PORT_BITS = 4'h0, PIN_BITS;
    int err_count = 0, check_count = 0, n, seed_v;
    logic [2:0] cs_seen;
    logic [19:0] a_pins;
    logic ext_seen;
    logic [7:0] rd_v;
    sbcc_top dut_u (.CLK(CLK), .RESETN(RESETN), .PROCESSOR_TYPE_PIN(PT), .LOW_SPEED_OSCILLATOR(LOW),
        .WR_MODE(WM), .WR_STACK_PAGE(WP), .WR_CONFIG(WC), .WR_DATA(WD), .INSTR_END(IE),
        .MODE_REG(MODE_REG), .STACK_PAGE_REG(STACK_PAGE_REG), .CONFIG_REG(CONFIG_REG),
        .BUS_EXPANSION(BUS_EXPANSION), .CPU_MAXIMUM(CPU_MAXIMUM), .INTERNAL_ROM_EN(INTERNAL_ROM_EN),
        .INT_MASK(INT_MASK), .ACC_REQ(REQ), .ACC_WRITE(AWR), .ACC_ADDR(AADR), .ACC_WDATA(AWD),
        .ACC_DONE(ACC_DONE), .ACC_RDATA(ACC_RDATA), .ACC_EXTERNAL(ACC_EXTERNAL), .STACK_POINTER(SPV),
        .STACK_ADDR(STACK_ADDR), .PORT_R_DATA(PORT_R_DATA), .PORT_P_DATA(PORT_P_DATA), .PORT_P_OE(PORT_P_OE),
        .PORT_BITS_30_33(PORT_BITS), .PIN_R_OUT(PIN_R_OUT), .PIN_P_IN(PIN_P_IN), .PIN_P_OUT(PIN_P_OUT),
        .PIN_P_OE(PIN_P_OE), .PIN_BITS_30_33(PIN_BITS), .BUS_REQUEST_IN(BRQ), .INPUT_PORT_BIT_3(IN3),
        .BUS_GRANT(BUS_GRANT));
    sbcc_ext_mem mem_u (.pin_r(PIN_R_OUT), .pin_p_out(PIN_P_OUT), .pin_p_oe(PIN_P_OE), .pin_p_in(PIN_P_IN));
    initial begin
        forever #20 CLK = ~CLK;
    end
    task automatic stop_test;
        if (err_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge CLK);
        #1;
    endtask : cyc
    task automatic rst(input logic pt);
        @(negedge CLK);
        RESETN = 1'b0;
        PT = pt;
        repeat (6) @(negedge CLK);
        RESETN = 1'b1;
        cyc(6);
    endtask : rst
    task automatic wr(input int sel, input logic [7:0] d);
        @(negedge CLK);
        WD = d;
        WM = (sel == 0);
        WP = (sel == 1);
        WC = (sel == 2);
        @(negedge CLK);
        {WM, WP, WC} = 3'b000;
        cyc(2);
    endtask : wr
    task automatic acc(input logic [23:0] a, input logic w, input logic [7:0] d);
        @(negedge CLK);
        {REQ, AWR, AADR, AWD} = {1'b1, w, a, d};
        n = 0;
        cs_seen = 3'b000;
        ext_seen = 1'b0;
        do begin
            cyc(1);
            n++;
            cs_seen |= ~PIN_BITS[2:0];
            ext_seen |= ACC_EXTERNAL;
            if (n == 2) a_pins = PIN_R_OUT[19:0];
            if (n > 60) begin
                err_count++;
                stop_test();
            end
        end while (ACC_DONE !== 1'b1);
        rd_v = ACC_RDATA;
        @(negedge CLK);
        REQ = 1'b0;
    endtask : acc
    function automatic logic [2:0] exp_cs(input logic [23:0] a, input logic rom);
        if (a[23:20] == 4'h1) return 3'b010;
        if (a[23:20] == 4'h2) return 3'b100;
        if (rom && a[23:20] == 4'h3) return 3'b001;
        if (!rom && a[23:20] == 4'h0 && !(a >= 24'h00D800 && a <= 24'h00FFFF)) return 3'b001;
        return 3'b000;
    endfunction : exp_cs
    initial begin
        logic [23:0] a;
        logic [2:0] code;
        logic [7:0] wv;
        seed_v = $urandom(32'h8f04);
        rst(1'b1);
        chk("bus_exp", BUS_EXPANSION, 0);
        chk("rom_en", INTERNAL_ROM_EN, 1);
        chk("mode", MODE_REG, 8'h00);
        chk("page", STACK_PAGE_REG, 8'h00);
        chk("config", CONFIG_REG, 8'h0C);
        chk("mask", INT_MASK, 1);
        @(negedge CLK);
        PORT_R_DATA = 22'($urandom);
        PORT_P_DATA = 8'($urandom);
        PORT_P_OE = 8'($urandom);
        PORT_BITS = 4'($urandom);
        BRQ = 1'b0;
        cyc(3);
        chk("r_pins", PIN_R_OUT, PORT_R_DATA);
        chk("p_pins", {PIN_P_OE, PIN_P_OUT}, {PORT_P_OE, PORT_P_DATA});
        chk("cs_port", PIN_BITS, PORT_BITS);
        chk("req_port", {IN3, BUS_GRANT}, 2'b00);
        @(negedge CLK);
        BRQ = 1'b1;
        PORT_BITS = 4'hF;
        wr(0, 8'hC7);
        chk("mode_set", {MODE_REG, BUS_EXPANSION, CPU_MAXIMUM}, {8'hC7, 2'b11});
        chk("in3", IN3, 1);
        @(negedge CLK);
        IE = 1'b1;
        @(negedge CLK);
        IE = 1'b0;
        cyc(2);
        chk("mask_half", INT_MASK, 1);
        wr(1, 8'h17);
        chk("mask_pg", INT_MASK, 1);
        @(negedge CLK);
        {IE, SPV} = {1'b1, 16'hFFFF};
        @(negedge CLK);
        IE = 1'b0;
        cyc(2);
        chk("mask_off", INT_MASK, 0);
        chk("stack", STACK_ADDR, 24'h17FFFF);
        for (int i = 0; i < 8; i++) begin
            code = i[2:0];
            wr(2, {1'b0, code, 4'hC});
            chk("cfg", CONFIG_REG, {1'b0, code, 4'hC});
            a = {2'b00, 2'(1 + $urandom_range(0, 2)), 20'($urandom)};
            acc(a, 1'b0, 8'h00);
            chk("cycles", n, 5 + 2 * i);
            chk("cs", cs_seen, exp_cs(a, 1'b1));
            chk("addr_pins", a_pins, a[19:0]);
            chk("rdata", rd_v, a[7:0] ^ 8'h5A);
        end
        acc(24'h00D800 + 24'($urandom_range(0, 16'h1FFF)), 1'b0, 8'h00);
        chk("int_cyc", {n[7:0], cs_seen, ext_seen}, {8'd5, 4'b0000});
        @(negedge CLK);
        LOW = 1'b1;
        acc(24'h2000C3, 1'b0, 8'h00);
        chk("slow_cyc", n, 5);
        @(negedge CLK);
        LOW = 1'b0;
        wv = 8'($urandom);
        acc(24'h2000AB, 1'b1, wv);
        acc(24'h2000AB, 1'b0, 8'h00);
        chk("wr_back", rd_v, wv);
        wr(2, 8'hFC);
        @(negedge CLK);
        BRQ = 1'b0;
        cyc(2);
        chk("grant", {BUS_GRANT, PIN_BITS[3]}, 2'b10);
        @(negedge CLK);
        BRQ = 1'b1;
        cyc(2);
        chk("ungrant", {BUS_GRANT, PIN_BITS[3]}, 2'b01);
        rst(1'b0);
        chk("mpu", {BUS_EXPANSION, INTERNAL_ROM_EN, MODE_REG}, {2'b10, 8'h81});
        wr(0, 8'h07);
        chk("mpu_mode", MODE_REG, 8'h87);
        a = 24'h00D000;
        for (int j = 0; j < 3; j++) begin
            acc(a, 1'b0, 8'h00);
            chk("mpu_cs", cs_seen, exp_cs(a, 1'b0));
            a = (j == 0) ? 24'h050000 + 24'($urandom_range(0, 16'hFFFF)) : 24'h00E000;
        end
        stop_test();
    end
endmodule : tb_top
